// file: design/dfp_pkg.sv
package dfp_pkg;

   // Measurements from the power stage, percent of rated values
   typedef struct packed {
      logic [11:0] out_current_pct;
      logic [11:0] bus_voltage_pct;
   } dfp_meas_type;

   // Supervisor states
   typedef enum logic [5:0] {
      ST_INIT  = 6'b000001,
      ST_GTEST = 6'b000010,
      ST_RUN   = 6'b000100,
      ST_WAIT  = 6'b001000,
      ST_ARST  = 6'b010000,
      ST_LOCK  = 6'b100000
   } dfp_state_type;

   // Register byte offsets
   localparam logic [7:0] CFG_OFS      = 8'h00;
   localparam logic [7:0] OVL_OFS      = 8'h04;
   localparam logic [7:0] STALL_OFS    = 8'h08;
   localparam logic [7:0] ARST_OFS     = 8'h0C;
   localparam logic [7:0] STATUS_OFS   = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
   localparam logic [7:0] CTRL_OFS     = 8'h1C;

   // Field positions
   localparam int CFG_OVL_EN_POS   = 0;
   localparam int CFG_GS_EN_POS    = 1;
   localparam int CFG_IPL_EN_POS   = 2;
   localparam int CFG_OPL_EN_POS   = 3;
   localparam int CFG_FDO_POS      = 4;
   localparam int OVL_GAIN_POS     = 0;
   localparam int OVL_COEF_POS     = 16;
   localparam int STALL_OVG_POS    = 0;
   localparam int STALL_OVT_POS    = 8;
   localparam int STALL_OCG_POS    = 16;
   localparam int STALL_OCT_POS    = 24;
   localparam int ARST_LIMIT_POS   = 0;
   localparam int ARST_INTV_POS    = 16;
   localparam int CTRL_UNLOCK_POS  = 0;
   localparam int IRQ_W            = 6;

   // Reset values and writable masks
   localparam logic [31:0] CFG_RST    = 32'h0000_001F;
   localparam logic [31:0] CFG_MASK   = 32'h0000_001F;
   localparam logic [31:0] OVL_RST    = 32'h0050_0064;
   localparam logic [31:0] OVL_MASK   = 32'h007F_03FF;
   localparam logic [31:0] STALL_RST  = 32'h9614_8200;
   localparam logic [31:0] STALL_MASK = 32'hFF7F_FF7F;
   localparam logic [31:0] ARST_RST   = 32'h000A_0000;
   localparam logic [31:0] ARST_MASK  = 32'h03FF_001F;

   // Timing: clock 10 MHz, slow tick 0.1 s, ground test 20 ms
   localparam int CLK_KHZ          = 10000;
   localparam int TICK_MS          = 100;
   localparam int GS_TEST_MS       = 20;
   localparam int TICK_CYCLES_DFLT = TICK_MS * CLK_KHZ;
   localparam int GS_CYCLES_DFLT   = GS_TEST_MS * CLK_KHZ;

   // Overload curve: base 150%, fast point 220%, 60 min vs 1 min
   localparam int OVL_BASE_PCT  = 150;
   localparam int OVL_FAST_PCT  = 220;
   localparam int OVL_SLOW_S    = 3600;
   localparam int OVL_FAST_S    = 60;
   localparam int TICKS_PER_S   = 1000 / TICK_MS;
   localparam int OVL_SPAN_PCT  = OVL_FAST_PCT - OVL_BASE_PCT;
   localparam int OVL_SLOPE     = OVL_SLOW_S / OVL_FAST_S - 1;
   localparam int OVL_LIM_BASE  = OVL_SLOW_S * TICKS_PER_S * OVL_SPAN_PCT;
   localparam int PCT_SCALE     = 100;

endpackage

// file: design/dfp_stall_hold.sv
`timescale 1ns/1ns
// Holds the ramp while a measurement sits above its stall threshold during deceleration
module dfp_stall_hold (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        decel,
   input  wire logic [6:0]  gain,
   input  wire logic [7:0]  threshold_pct,
   input  wire logic [11:0] level_pct,
   output logic             hold
);
   import dfp_pkg::*;

   wire stall_on = (gain != 7'h00);
   wire over     = (level_pct > {4'h0, threshold_pct});

   // Hold only during deceleration, release once level falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold <= 1'b0;
      end else begin
         hold <= stall_on & decel & over;
      end
   end

endmodule // dfp_stall_hold

// file: design/dfp_overload_acc.sv
`timescale 1ns/1ns
// Inverse-time heat accumulator with pre-alarm
module dfp_overload_acc (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        enable,
   input  wire logic        clear,
   input  wire logic [11:0] current_pct,
   input  wire logic [9:0]  gain,
   input  wire logic [6:0]  coef,
   output logic             fault,
   output logic             prealarm
);
   import dfp_pkg::*;

   logic [39:0] acc_reg;
   logic [39:0] acc_next;

   wire [39:0] gain_w = {30'h0000_0000, gain};
   wire [39:0] x100   = {28'h000_0000, current_pct} * 40'(PCT_SCALE);
   wire [39:0] t_base = gain_w * 40'(OVL_BASE_PCT);
   wire        above  = (x100 >= t_base);
   wire [39:0] cool   = gain_w * 40'(OVL_SPAN_PCT);
   wire [39:0] heat   = cool + 40'(OVL_SLOPE) * (x100 - t_base);
   wire [39:0] limit  = gain_w * 40'(OVL_LIM_BASE);
   wire [39:0] sum    = acc_reg + heat;
   wire        warn   = (acc_reg * 40'(PCT_SCALE)) > (limit * {33'h0_0000_0000, coef});

   // Heat when above the base level, cool otherwise
   always_comb begin
      acc_next = acc_reg;
      if (!enable || clear) begin
         acc_next = 40'h00_0000_0000;
      end else if (tick) begin
         if (above) begin
            acc_next = (sum >= limit) ? limit : sum;
         end else begin
            acc_next = (acc_reg > cool) ? acc_reg - cool : 40'h00_0000_0000;
         end
      end
   end

   // Accumulator and outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg  <= 40'h00_0000_0000;
         fault    <= 1'b0;
         prealarm <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         fault    <= enable & (acc_reg >= limit) & (limit != 40'h00_0000_0000);
         prealarm <= enable & warn;
      end
   end

endmodule // dfp_overload_acc

// file: design/dfp_top.sv
`timescale 1ns/1ns
module dfp_top #(
   parameter int TICK_CYCLES = dfp_pkg::TICK_CYCLES_DFLT,
   parameter int GS_CYCLES   = dfp_pkg::GS_CYCLES_DFLT
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire dfp_pkg::dfp_meas_type meas,
   input  wire logic                 decelerating,
   input  wire logic                 ground_fault_sense,
   input  wire logic                 input_phase_lost,
   input  wire logic                 output_phase_lost,
   input  wire logic                 heavy_duty_model,
   output logic                      freq_hold,
   output logic                      output_phase_terminals_drive,
   output logic                      overload_prealarm,
   output logic                      fault_out,
   output logic                      fault_auto_reset,
   output logic                      irq
);
   import dfp_pkg::*;

   // Registers
   logic [31:0]        cfg_reg;
   logic [31:0]        ovl_reg;
   logic [31:0]        stall_reg;
   logic [31:0]        arst_reg;
   logic [IRQ_W-1:0]   irq_stat_reg;
   logic [IRQ_W-1:0]   irq_stat_next;
   logic [IRQ_W-1:0]   irq_mask_reg;
   logic [IRQ_W-1:0]   lvl_prev_reg;
   dfp_state_type      state_reg;
   dfp_state_type      state_next;
   logic [4:0]         retry_reg;
   logic [4:0]         retry_next;
   logic [9:0]         wait_reg;
   logic [9:0]         wait_next;
   logic [31:0]        tick_cnt_reg;
   logic               tick_reg;
   logic [31:0]        gs_cnt_reg;
   logic               hd_reg;
   logic               ov_hold;
   logic               oc_hold;
   logic               ovl_fault;
   logic               ovl_pre;

   // Field extraction
   wire        ovl_en    = cfg_reg[CFG_OVL_EN_POS];
   wire        gs_en     = cfg_reg[CFG_GS_EN_POS];
   wire        ipl_en    = cfg_reg[CFG_IPL_EN_POS];
   wire        opl_en    = cfg_reg[CFG_OPL_EN_POS];
   wire        fdo_sel   = cfg_reg[CFG_FDO_POS];
   wire [9:0]  ovl_gain  = ovl_reg[OVL_GAIN_POS +: 10];
   wire [6:0]  ovl_coef  = ovl_reg[OVL_COEF_POS +: 7];
   wire [6:0]  ov_gain   = stall_reg[STALL_OVG_POS +: 7];
   wire [7:0]  ov_thr    = stall_reg[STALL_OVT_POS +: 8];
   wire [6:0]  oc_gain   = stall_reg[STALL_OCG_POS +: 7];
   wire [7:0]  oc_thr    = stall_reg[STALL_OCT_POS +: 8];
   wire [4:0]  rst_limit = arst_reg[ARST_LIMIT_POS +: 5];
   wire [9:0]  rst_intv  = arst_reg[ARST_INTV_POS +: 10];
   wire [9:0]  intv_eff  = (rst_intv == 10'h000) ? 10'h001 : rst_intv;

   // APB decode
   wire setup_ph   = psel & ~penable;
   wire access_ok  = psel & penable & pready;
   wire wr_en      = access_ok & pwrite;
   wire sel_cfg    = (paddr == CFG_OFS);
   wire sel_ovl    = (paddr == OVL_OFS);
   wire sel_stall  = (paddr == STALL_OFS);
   wire sel_arst   = (paddr == ARST_OFS);
   wire sel_status = (paddr == STATUS_OFS);
   wire sel_istat  = (paddr == IRQ_STAT_OFS);
   wire sel_imask  = (paddr == IRQ_MASK_OFS);
   wire sel_ctrl   = (paddr == CTRL_OFS);
   wire mapped     = sel_cfg | sel_ovl | sel_stall | sel_arst | sel_status | sel_istat | sel_imask | sel_ctrl;
   wire unlock     = wr_en & sel_ctrl & pwdata[CTRL_UNLOCK_POS];

   // Status word
   wire [31:0] status_word = {11'h000, hd_reg, fault_out, overload_prealarm, oc_hold, ov_hold,
                              3'h0, retry_reg, 2'h0, state_reg};

   // Read data selection
   wire [31:0] rd_data = sel_cfg    ? cfg_reg :
                         sel_ovl    ? ovl_reg :
                         sel_stall  ? stall_reg :
                         sel_arst   ? arst_reg :
                         sel_status ? status_word :
                         sel_istat  ? {26'h000_0000, irq_stat_reg} :
                         sel_imask  ? {26'h000_0000, irq_mask_reg} :
                         32'h0000_0000;

   // No wait state: answer registered at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~mapped;
         prdata  <= (setup_ph && !pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // Setting registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg      <= CFG_RST;
         ovl_reg      <= OVL_RST;
         stall_reg    <= STALL_RST;
         arst_reg     <= ARST_RST;
         irq_mask_reg <= {IRQ_W{1'b0}};
      end else if (wr_en) begin
         if (sel_cfg)   cfg_reg      <= pwdata & CFG_MASK;
         if (sel_ovl)   ovl_reg      <= pwdata & OVL_MASK;
         if (sel_stall) stall_reg    <= pwdata & STALL_MASK;
         if (sel_arst)  arst_reg     <= pwdata & ARST_MASK;
         if (sel_imask) irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
   end

   // Slow tick, 0.1 s
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         tick_reg     <= 1'b0;
      end
   end

   // Overload accumulator
   dfp_overload_acc u_ovl (
      .pclk        (pclk),
      .presetn     (presetn),
      .tick        (tick_reg),
      .enable      (ovl_en),
      .clear       ((state_reg == ST_ARST) | unlock),
      .current_pct (meas.out_current_pct),
      .gain        (ovl_gain),
      .coef        (ovl_coef),
      .fault       (ovl_fault),
      .prealarm    (ovl_pre)
   );

   // Overvoltage stall
   dfp_stall_hold u_ov_stall (
      .pclk          (pclk),
      .presetn       (presetn),
      .decel         (decelerating),
      .gain          (ov_gain),
      .threshold_pct (ov_thr),
      .level_pct     (meas.bus_voltage_pct),
      .hold          (ov_hold)
   );

   // Overcurrent stall
   dfp_stall_hold u_oc_stall (
      .pclk          (pclk),
      .presetn       (presetn),
      .decel         (decelerating),
      .gain          (oc_gain),
      .threshold_pct (oc_thr),
      .level_pct     (meas.out_current_pct),
      .hold          (oc_hold)
   );

   // Fault sources
   wire ipl_fault = ipl_en & hd_reg & input_phase_lost;
   wire opl_fault = opl_en & output_phase_lost;
   wire gs_fault  = (state_reg == ST_GTEST) & ground_fault_sense;
   wire any_fault = ovl_fault | ipl_fault | opl_fault | gs_fault;
   wire can_retry = (retry_reg < rst_limit);
   wire gs_done   = (gs_cnt_reg >= 32'(GS_CYCLES - 1));

   // Supervisor next state
   always_comb begin
      state_next = state_reg;
      retry_next = retry_reg;
      wait_next  = wait_reg;
      unique case (state_reg)
         ST_INIT: begin
            state_next = gs_en ? ST_GTEST : ST_RUN;
         end
         ST_GTEST, ST_RUN: begin
            if (any_fault) begin
               state_next = can_retry ? ST_WAIT : ST_LOCK;
               wait_next  = 10'h000;
            end else if (state_reg == ST_GTEST && gs_done) begin
               state_next = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (tick_reg) begin
               wait_next = wait_reg + 10'h001;
               if (wait_reg + 10'h001 >= intv_eff) begin
                  state_next = ST_ARST;
               end
            end
         end
         ST_ARST: begin
            retry_next = retry_reg + 5'h01;
            state_next = ST_RUN;
         end
         ST_LOCK: begin
            if (unlock) begin
               state_next = ST_RUN;
               retry_next = 5'h00;
            end
         end
      endcase
   end

   // Supervisor state and ground test timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= ST_INIT;
         retry_reg  <= 5'h00;
         wait_reg   <= 10'h000;
         gs_cnt_reg <= 32'h0000_0000;
      end else begin
         state_reg  <= state_next;
         retry_reg  <= retry_next;
         wait_reg   <= wait_next;
         gs_cnt_reg <= (state_reg == ST_GTEST) ? gs_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   // Model strap caught once after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hd_reg <= 1'b0;
      end else if (state_reg == ST_INIT) begin
         hd_reg <= heavy_duty_model;
      end
   end

   // Output flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_hold                    <= 1'b0;
         output_phase_terminals_drive <= 1'b0;
         overload_prealarm            <= 1'b0;
         fault_out                    <= 1'b0;
         fault_auto_reset             <= 1'b0;
      end else begin
         freq_hold                    <= ov_hold | oc_hold;
         output_phase_terminals_drive <= (state_next == ST_GTEST);
         overload_prealarm            <= ovl_pre;
         fault_out                    <= (state_next == ST_LOCK) |
                                         ((state_next == ST_WAIT) & fdo_sel) |
                                         ((state_next == ST_ARST) & fdo_sel);
         fault_auto_reset             <= (state_next == ST_ARST);
      end
   end

   // Event levels: lock, output loss, input loss, ground, pre-alarm, overload
   wire [IRQ_W-1:0] lvl    = {state_reg == ST_LOCK, opl_fault, ipl_fault, gs_fault, ovl_pre, ovl_fault};
   wire [IRQ_W-1:0] events = lvl & ~lvl_prev_reg;
   wire [IRQ_W-1:0] w1c    = (wr_en & sel_istat) ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

   // Sticky status, set wins over clear
   always_comb begin
      irq_stat_next = (irq_stat_reg & ~w1c) | events;
   end

   // Interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= {IRQ_W{1'b0}};
         lvl_prev_reg <= {IRQ_W{1'b0}};
         irq          <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         lvl_prev_reg <= lvl;
         irq          <= |(irq_stat_next & irq_mask_reg);
      end
   end

endmodule // dfp_top

// file: tb/dfp_chk.sv
`timescale 1ns/1ns
// Port-level timing checks
module dfp_chk #(parameter int GS_CYCLES = 20) (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire dfp_pkg::dfp_meas_type meas,
   input wire logic                  decelerating,
   input wire logic                  freq_hold,
   input wire logic                  output_phase_terminals_drive,
   input wire logic                  fault_out,
   input wire logic                  fault_auto_reset
);
   import dfp_pkg::*;
   logic [31:0] drv_cnt_reg;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Length of the present drive burst
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_cnt_reg <= 32'h0;
      end else begin
         drv_cnt_reg <= output_phase_terminals_drive ? drv_cnt_reg + 32'h1 : 32'h0;
      end
   end
   a_access_follows: assert property ((psel && !penable) |=> pready)
      else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside access");
   // A short found mid-test cuts the burst and, when it locks or fdo_sel is set, raises the fault output at the same edge
   a_gs_drive_len: assert property (($fell(output_phase_terminals_drive) && !fault_out) |->
      drv_cnt_reg == GS_CYCLES)
      else $error("ground test burst length wrong");
   a_gs_drive_max: assert property (drv_cnt_reg <= GS_CYCLES)
      else $error("ground test burst too long");
   a_hold_decel: assert property ($rose(freq_hold) |-> $past(decelerating, 2))
      else $error("hold without deceleration");
   a_hold_level: assert property ($rose(freq_hold) |->
      ($past(meas.out_current_pct, 2) > 12'h064 || $past(meas.bus_voltage_pct, 2) > 12'h078))
      else $error("hold without overlevel");
   a_hold_release: assert property ($fell(decelerating) |-> ##[1:3] !freq_hold)
      else $error("hold kept after deceleration ended");
   a_pulse_single: assert property (fault_auto_reset |=> !fault_auto_reset)
      else $error("auto reset pulse too long");
endmodule // dfp_chk

bind dfp_top dfp_chk #(.GS_CYCLES(GS_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
   .decelerating(decelerating), .freq_hold(freq_hold),
   .output_phase_terminals_drive(output_phase_terminals_drive), .fault_out(fault_out),
   .fault_auto_reset(fault_auto_reset));

// file: tb/dfp_stage_model.sv
`timescale 1ns/1ns
// Power stage stand-in, sensing lags commands by a cycle
module dfp_stage_model (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [11:0]           cur_cmd,
   input  wire logic [11:0]           bus_cmd,
   input  wire logic                  decel_cmd,
   input  wire logic                  short_cmd,
   input  wire logic                  ipl_cmd,
   input  wire logic                  opl_cmd,
   input  wire logic                  drive,
   output dfp_pkg::dfp_meas_type      meas,
   output logic                       decelerating,
   output logic                       ground_fault_sense,
   output logic                       input_phase_lost,
   output logic                       output_phase_lost
);
   import dfp_pkg::*;
   // Sensed values and loss flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas               <= '0;
         decelerating       <= 1'b0;
         ground_fault_sense <= 1'b0;
         input_phase_lost   <= 1'b0;
         output_phase_lost  <= 1'b0;
      end else begin
         meas               <= '{out_current_pct: cur_cmd, bus_voltage_pct: bus_cmd};
         decelerating       <= decel_cmd;
         ground_fault_sense <= drive & short_cmd; // Earth current only under test voltage
         input_phase_lost   <= ipl_cmd;
         output_phase_lost  <= opl_cmd;
      end
   end
endmodule // dfp_stage_model

// file: tb/drive_fault_protection_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module drive_fault_protection_tb;
   import dfp_pkg::*;
   localparam int TK = 10;
   logic pclk, presetn, psel, penable, pwrite, heavy, pready, pslverr, err, hold, drive;
   logic pre, fault_out, pulse, irq, decel, shrt, ipl, opl, dec_w, gs_w, ipl_w, opl_w;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, st;
   logic [11:0] cur, bus;
   logic [15:0] lfsr;
   dfp_meas_type meas;
   int fail_count, compares, cyc, t0, pa, n;
   logic [31:0] rst_val [4] = '{32'h0000_001F, 32'h0050_0064, 32'h9614_8200, 32'h000A_0000};
   dfp_top #(.TICK_CYCLES(TK), .GS_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas(meas), .decelerating(dec_w), .ground_fault_sense(gs_w),
      .input_phase_lost(ipl_w), .output_phase_lost(opl_w), .heavy_duty_model(heavy), .freq_hold(hold),
      .output_phase_terminals_drive(drive), .overload_prealarm(pre), .fault_out(fault_out),
      .fault_auto_reset(pulse), .irq(irq));
   dfp_stage_model i_stage (.pclk(pclk), .presetn(presetn), .cur_cmd(cur), .bus_cmd(bus),
      .decel_cmd(decel), .short_cmd(shrt), .ipl_cmd(ipl), .opl_cmd(opl), .drive(drive), .meas(meas),
      .decelerating(dec_w), .ground_fault_sense(gs_w), .input_phase_lost(ipl_w), .output_phase_lost(opl_w));
   // Clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic exp_hold(logic d, logic [11:0] c, logic [11:0] v, logic [31:0] s);
      return d && ((s[22:16] != 7'h0 && c > s[31:24]) || (s[6:0] != 7'h0 && v > s[15:8]));
   endfunction
   // Ticks until the heat passes pct percent of the trip level
   function automatic int ovl_ticks(int c, int g, int pct);
      longint inc;
      inc = 70 * g + 59 * (c * 100 - 150 * g);
      return int'((longint'(2520000) * g * pct / 100 + inc - 1) / inc);
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends when pready rises; only the hang guard ends it if pready never does
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      t0 = 0;
      while (s !== 1'b1 && t0 < lim) begin
         @(posedge pclk);
         t0++;
      end
   endtask
   task automatic do_reset(input logic hv);
      presetn <= 1'b0;
      heavy <= hv;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic fault_blip();
      opl <= 1'b1;
      repeat (3) @(posedge pclk);
      opl <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {psel, penable, pwrite, presetn, heavy, decel, shrt, ipl, opl} = 9'h0;
      {paddr, pwdata, cur, bus, lfsr} = {8'h0, 32'h0, 12'h0, 12'h064, 16'h0029};
      do_reset(1'b0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK("reset value", rst_val[i], rd)
      end
      `CHK("test drive", 1'b1, drive)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
      repeat (30) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("state after test", 7'h04, {rd[20], rd[5:0]})
      for (int i = 0; i < 32; i++) begin
         if (i % 16 == 0) begin
            st = (i == 0) ? 32'h9614_820A : 32'h9600_8200;
            apb(1'b1, STALL_OFS, st);
         end
         lfsr = nxt(lfsr);
         cur <= (i == 1) ? 12'h096 : {4'h0, lfsr[7:0]};
         bus <= 12'h064 + {6'h0, lfsr[13:8]};
         decel <= lfsr[15] | (i < 2);
         repeat (5) @(posedge pclk);
         `CHK("hold", exp_hold(decel, cur, bus, st), hold)
      end
      decel <= 1'b0;
      cur <= 12'h0;
      ipl <= 1'b1;
      apb(1'b1, CFG_OFS, 32'h17);
      opl <= 1'b1;
      repeat (30) @(posedge pclk);
      `CHK("loss ignored", 1'b0, fault_out)
      {ipl, opl} <= 2'b00;
      apb(1'b1, ARST_OFS, 32'h0002_0002);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, CFG_OFS, {27'h0, i[0], 4'hF});
         fault_blip();
         `CHK("fault out in retry", i[0], fault_out)
         wait_hi(pulse, 60);
         `CHK("retry gap", 1'b1, t0 >= TK / 2 && t0 <= 2 * TK + 2)
      end
      fault_blip();
      repeat (40) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("lock", 8'hC4, {rd[5], fault_out, rd[12:8], pulse})
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      `CHK("event sticky", 2'b11, {rd[4], rd[5]})
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, (i == 2) ? IRQ_STAT_OFS : IRQ_MASK_OFS, (i == 0) ? 32'h0 : 32'h10);
         repeat (2) @(posedge pclk);
         `CHK("irq", i == 1, irq)
      end
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b1, ARST_OFS, 32'h000A_0000);
      apb(1'b1, OVL_OFS, 32'h0050_0014);
      apb(1'b1, CFG_OFS, 32'h1E);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("unlocked", 6'h04, rd[5:0])
      cur <= 12'd300;
      repeat (40 * TK) @(posedge pclk);
      `CHK("overload off", 2'b00, {pre, fault_out})
      cur <= 12'h0;
      apb(1'b1, CFG_OFS, 32'h1F);
      apb(1'b1, CTRL_OFS, 32'h1);
      cur <= 12'd300;
      wait_hi(pre, 600);
      pa = t0;
      wait_hi(fault_out, 600);
      n = ovl_ticks(300, 20, 80);
      `CHK("prealarm time", 1'b1, pa >= (n - 1) * TK && pa <= (n + 1) * TK)
      n = ovl_ticks(300, 20, 100);
      `CHK("trip time", 1'b1, pa + t0 >= (n - 1) * TK && pa + t0 <= (n + 1) * TK)
      cur <= 12'h0;
      shrt <= 1'b1;
      do_reset(1'b1);
      repeat (30) @(posedge pclk);
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      `CHK("ground short", 3'b111, {rd[2], rd[5], fault_out})
      shrt <= 1'b0;
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b1, CFG_OFS, 32'h1B);
      ipl <= 1'b1;
      repeat (10) @(posedge pclk);
      `CHK("ipl disabled", 1'b0, fault_out)
      apb(1'b1, CFG_OFS, 32'h1F);
      repeat (5) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("heavy ipl fault", 2'b11, {rd[20], fault_out})
      end_of_test();
   end
endmodule // drive_fault_protection_tb
